// ### design/loop_path.sv
// MII receive path with loopback select and post-enable dead time
`default_nettype none
module loop_path #(
	parameter int unsigned DEAD_CYCLES = phy_bmc_pkg::DEAD_CYCLES
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       loop_en,
	input  wire logic [3:0] mii_txd,
	input  wire logic       mii_tx_en,
	input  wire logic [3:0] line_rxd,
	input  wire logic       line_rx_dv,
	output var  logic [3:0] mii_rxd_q,
	output var  logic       mii_rx_dv_q,
	output var  logic       dead_q
);
	localparam int unsigned CW = $clog2(DEAD_CYCLES + 1);

	if (DEAD_CYCLES < 2) begin : g_chk
		$error("loop_path: DEAD_CYCLES must be at least 2");
	end

	logic          loop_prev_q;
	logic [CW-1:0] cnt_q;

	// Descrambler relock is modelled as always needed on enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_prev_q <= 1'b0;
			cnt_q       <= '0;
			dead_q      <= 1'b0;
		end else begin
			loop_prev_q <= loop_en;
			if (loop_en && !loop_prev_q) begin
				cnt_q  <= CW'(DEAD_CYCLES);
				dead_q <= 1'b1;
			end else if (dead_q) begin
				cnt_q <= cnt_q - CW'(1);
				if (cnt_q == CW'(1)) begin
					dead_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mii_rxd_q   <= 4'h0;
			mii_rx_dv_q <= 1'b0;
		end else begin
			mii_rxd_q   <= loop_en ? mii_txd : line_rxd;
			// Blank the enable cycle too, before the dead flag is up
			mii_rx_dv_q <= !dead_q && !(loop_en && !loop_prev_q)
				&& (loop_en ? mii_tx_en : line_rx_dv);
		end
	end

	AST_LOOP_ROUTE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(loop_en && !dead_q) |=> (mii_rxd_q == $past(mii_txd)
			&& mii_rx_dv_q == ($past(mii_tx_en) && $past(loop_prev_q))))
		else $error("Loopback data not routed to receive path");

	AST_DEAD_BLANK: assert property (
		@(posedge pclk) disable iff (!presetn)
		(loop_en && !loop_prev_q) |=> (dead_q && !mii_rx_dv_q) ##1 !mii_rx_dv_q)
		else $error("Receive valid seen during dead time");

	AST_SC_ENDS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(dead_q && cnt_q == CW'(1) && !(loop_en && !loop_prev_q)) |=> !dead_q)
		else $error("Dead time flag did not self clear");
endmodule : loop_path
`default_nettype wire

// ### design/phy_basic_mode_control.sv
// Basic mode control register bank with APB slave and status bit conventions
// Overview of operation
// - Writing one to bit 15 starts a software reset that reads one until it self-clears.
// - Completing a software reset reloads the strap configuration as a hardware reset does.
// - Bit 14 set routes MII transmit data onto the MII receive path, clear means normal.
// - Enabling loopback may blank valid receive data for up to 500 us.
// - With auto-negotiation off, bit 13 selects 100 Mb/s when one and 10 Mb/s when zero.
// - Bit 12 loads from its strap at reset and is read-write afterwards.
// - With auto-negotiation on, bits 13 and 8 are ignored for the link mode.
// - With auto-negotiation off, speed comes from bit 13 and duplex from bit 8.
// - With auto-negotiation off, writes to bit 8 select the duplex mode.
// - A self-clearing status bit sets on its event and clears when the event ends.
// - A clear-on-read bit returns its value and is cleared by that same read.
// - A latched-low bit holds zero after its event until read, then follows its source.
// - A latched-high bit holds one after its event until read, then follows its source.
// - A permanent read-only bit always returns its fixed value and ignores writes.
`default_nettype none
module phy_basic_mode_control
	import phy_bmc_pkg::*;
#(
	parameter int unsigned RESET_CYCLES = phy_bmc_pkg::SW_RESET_CYCLES,
	parameter int unsigned DEAD_CYCLES  = phy_bmc_pkg::DEAD_CYCLES
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [phy_bmc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [phy_bmc_pkg::DATA_W-1:0] pwdata,
	output var  logic [phy_bmc_pkg::DATA_W-1:0] prdata,
	output var  logic                           pready,
	output var  logic                           pslverr,
	input  wire logic                           strap_an_enable,
	input  wire logic                           strap_speed_100,
	input  wire logic                           strap_full_duplex,
	input  wire logic                           an_speed_100,
	input  wire logic                           an_full_duplex,
	input  wire logic                           link_up_src,
	input  wire logic                           jabber_src,
	input  wire logic                           false_carrier_evt,
	input  wire logic [3:0]                     mii_txd,
	input  wire logic                           mii_tx_en,
	input  wire logic [3:0]                     line_rxd,
	input  wire logic                           line_rx_dv,
	output var  logic [3:0]                     mii_rxd,
	output var  logic                           mii_rx_dv,
	output var  logic                           link_speed_100,
	output var  logic                           link_full_duplex,
	output var  logic                           an_enable,
	output var  logic                           soft_reset_active
);
	if (RESET_CYCLES < 2 || DEAD_CYCLES < 2) begin : g_chk
		$error("phy_basic_mode_control: cycle counts must be at least 2");
	end

	// Bus state
	logic              pready_q;
	logic              pslverr_q;
	logic [DATA_W-1:0] prdata_q;

	// Control bits
	logic loop_q;
	logic speed_q;
	logic an_en_q;
	logic duplex_q;
	logic load_pend_q;

	// Status bits
	logic link_ll_q;
	logic jab_lh_q;
	logic fcs_cor_q;

	// Link mode outputs
	logic speed_out_q;
	logic duplex_out_q;

	// Submodule results
	logic       busy;
	logic       reload;
	logic       dead;
	logic [3:0] rxd_w;
	logic       rx_dv_w;

	// Decode
	logic              acc_first;
	logic              acc_done;
	logic              hit_bmc;
	logic              hit_st;
	logic              wr_bmc;
	logic              clr_st;
	logic [REG_W-1:0]  bmc_rd;
	logic [REG_W-1:0]  st_rd;
	logic [DATA_W-1:0] rd_mux;

	assign hit_bmc   = (paddr == BMC_OFFSET);
	assign hit_st    = (paddr == STAT_OFFSET);
	// One wait state so read data and pready leave flip-flops
	assign acc_first = psel && penable && !pready_q;
	assign acc_done  = psel && penable && pready_q;
	// Writes during a software reset are dropped; the reload would undo them
	assign wr_bmc    = acc_done && pwrite && hit_bmc && !busy;
	// Only bits actually returned are cleared, so later events survive
	assign clr_st    = acc_done && !pwrite && hit_st;

	always_comb begin
		bmc_rd             = '0;
		bmc_rd[RESET_BIT]  = busy;
		bmc_rd[LOOP_BIT]   = loop_q;
		bmc_rd[SPEED_BIT]  = speed_q;
		bmc_rd[AN_EN_BIT]  = an_en_q;
		bmc_rd[DUPLEX_BIT] = duplex_q;
	end

	always_comb begin
		st_rd                          = '0;
		st_rd[ST_LINK_BIT]             = link_ll_q;
		st_rd[ST_JAB_BIT]              = jab_lh_q;
		st_rd[ST_FCS_BIT]              = fcs_cor_q;
		st_rd[ST_DEAD_BIT]             = dead;
		st_rd[ST_CAP_LSB+3:ST_CAP_LSB] = PERM_CAP;
	end

	always_comb begin
		rd_mux = '0;
		if (hit_bmc) begin
			rd_mux[REG_W-1:0] = bmc_rd;
		end else if (hit_st) begin
			rd_mux[REG_W-1:0] = st_rd;
		end
	end

	// APB slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= acc_first;
			pslverr_q <= acc_first && !(hit_bmc || hit_st);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (acc_first) begin
			prdata_q <= pwrite ? '0 : rd_mux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_q      <= LOOP_RST;
			speed_q     <= 1'b0;
			an_en_q     <= 1'b0;
			duplex_q    <= 1'b0;
			load_pend_q <= 1'b1;
		end else if (load_pend_q || reload) begin
			// Straps are sampled after release, never by the async reset
			an_en_q     <= strap_an_enable;
			speed_q     <= strap_speed_100;
			duplex_q    <= strap_full_duplex;
			loop_q      <= LOOP_RST;
			load_pend_q <= 1'b0;
		end else if (wr_bmc) begin
			loop_q   <= pwdata[LOOP_BIT];
			speed_q  <= pwdata[SPEED_BIT];
			an_en_q  <= pwdata[AN_EN_BIT];
			duplex_q <= pwdata[DUPLEX_BIT];
		end
	end

	// Link mode selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_out_q  <= 1'b0;
			duplex_out_q <= 1'b0;
		end else if (an_en_q) begin
			speed_out_q  <= an_speed_100;
			duplex_out_q <= an_full_duplex;
		end else begin
			speed_out_q  <= speed_q;
			duplex_out_q <= duplex_q;
		end
	end

	assign link_speed_100   = speed_out_q;
	assign link_full_duplex = duplex_out_q;
	assign an_enable        = an_en_q;

	// Latched-low link bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_ll_q <= 1'b0;
		end else if (clr_st && !prdata_q[ST_LINK_BIT]) begin
			link_ll_q <= link_up_src;
		end else begin
			link_ll_q <= link_ll_q && link_up_src;
		end
	end

	// Latched-high jabber bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jab_lh_q <= 1'b0;
		end else if (clr_st && prdata_q[ST_JAB_BIT]) begin
			jab_lh_q <= jabber_src;
		end else begin
			jab_lh_q <= jab_lh_q || jabber_src;
		end
	end

	// Clear-on-read false carrier bit; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcs_cor_q <= 1'b0;
		end else begin
			fcs_cor_q <= (fcs_cor_q && !(clr_st && prdata_q[ST_FCS_BIT]))
				|| false_carrier_evt;
		end
	end

	sw_reset_seq #(
		.CYCLES (RESET_CYCLES)
	) u_rst (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (wr_bmc && pwdata[RESET_BIT]),
		.busy_q   (busy),
		.reload_q (reload)
	);

	loop_path #(
		.DEAD_CYCLES (DEAD_CYCLES)
	) u_loop (
		.pclk        (pclk),
		.presetn     (presetn),
		.loop_en     (loop_q),
		.mii_txd     (mii_txd),
		.mii_tx_en   (mii_tx_en),
		.line_rxd    (line_rxd),
		.line_rx_dv  (line_rx_dv),
		.mii_rxd_q   (rxd_w),
		.mii_rx_dv_q (rx_dv_w),
		.dead_q      (dead)
	);

	assign mii_rxd           = rxd_w;
	assign mii_rx_dv         = rx_dv_w;
	assign soft_reset_active = busy;

	AST_SWRST_START: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_bmc && pwdata[RESET_BIT]) |=> busy ##1 (!(acc_first && hit_bmc && !pwrite)
			or ##1 prdata_q[RESET_BIT]))
		else $error("Software reset did not start or read back one");

	AST_SWRST_READ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(acc_first && hit_bmc && !pwrite && busy) |=> prdata_q[RESET_BIT])
		else $error("Reset bit read zero while reset runs");

	AST_STRAP_RELOAD: assert property (
		@(posedge pclk) disable iff (!presetn)
		reload |=> (an_en_q == $past(strap_an_enable) && speed_q == $past(strap_speed_100)
			&& duplex_q == $past(strap_full_duplex) && !loop_q))
		else $error("Straps not reloaded after software reset");

	AST_HW_STRAP: assert property (
		@(posedge pclk) disable iff (!presetn)
		load_pend_q |=> (an_en_q == $past(strap_an_enable) && !load_pend_q))
		else $error("Strap not loaded after hardware reset");

	AST_AN_IGNORES: assert property (
		@(posedge pclk) disable iff (!presetn)
		an_en_q |=> (speed_out_q == $past(an_speed_100)
			&& duplex_out_q == $past(an_full_duplex)))
		else $error("Forced bits used while auto-negotiation enabled");

	AST_FORCED_MODE: assert property (
		@(posedge pclk) disable iff (!presetn)
		!an_en_q |=> (speed_out_q == $past(speed_q) && duplex_out_q == $past(duplex_q)))
		else $error("Forced speed or duplex not applied");

	AST_COR_CLEARS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clr_st && prdata_q[ST_FCS_BIT] && !false_carrier_evt) |=> !fcs_cor_q)
		else $error("Clear-on-read bit survived its read");

	AST_LL_HOLDS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!link_ll_q && !clr_st) |=> !link_ll_q)
		else $error("Latched-low bit released without a read");

	AST_LH_HOLDS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(jab_lh_q && !clr_st) |=> jab_lh_q)
		else $error("Latched-high bit released without a read");

	AST_PERM_BITS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(pready_q && hit_st && !pwrite) |-> prdata_q[ST_CAP_LSB+3:ST_CAP_LSB] == PERM_CAP)
		else $error("Permanent bits read a wrong value");

	AST_ANSWER: assert property (
		@(posedge pclk) disable iff (!presetn)
		acc_first |=> (pready_q && pslverr_q == $past(!(hit_bmc || hit_st))))
		else $error("Access not answered in one wait state");
endmodule : phy_basic_mode_control
`default_nettype wire

// ### design/sw_reset_seq.sv
// Software reset sequencer: busy window then one reload pulse
`default_nettype none
module sw_reset_seq
	import phy_bmc_pkg::*;
#(
	parameter int unsigned CYCLES = phy_bmc_pkg::SW_RESET_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output var  logic busy_q,
	output var  logic reload_q
);
	localparam int unsigned CW = $clog2(CYCLES + 1);

	if (CYCLES < 2) begin : g_chk
		$error("sw_reset_seq: CYCLES must be at least 2");
	end

	rst_state_t        state_q;
	logic     [CW-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= RS_IDLE;
			cnt_q    <= '0;
			busy_q   <= 1'b0;
			reload_q <= 1'b0;
		end else begin
			case (state_q)
				RS_IDLE: begin
					reload_q <= 1'b0;
					if (start) begin
						state_q <= RS_RUN;
						cnt_q   <= '0;
						busy_q  <= 1'b1;
					end
				end
				RS_RUN: begin
					cnt_q <= cnt_q + CW'(1);
					if (cnt_q == CW'(CYCLES - 1)) begin
						state_q  <= RS_RELOAD;
						reload_q <= 1'b1;
					end
				end
				RS_RELOAD: begin
					state_q  <= RS_IDLE;
					busy_q   <= 1'b0;
					reload_q <= 1'b0;
				end
				default: begin
					state_q <= RS_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	AST_RESET_LENGTH: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state_q == RS_RUN && cnt_q == CW'(CYCLES - 1)) |=> reload_q ##1 !busy_q)
		else $error("Reset busy window has wrong length");
endmodule : sw_reset_seq
`default_nettype wire

// ### shared/phy_bmc_pkg.sv
// Shared constants for the basic mode control register block
`default_nettype none
package phy_bmc_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 16;

	localparam logic [7:0] BMC_OFFSET  = 8'h00;
	localparam logic [7:0] STAT_OFFSET = 8'h04;

	// Control field positions
	localparam int unsigned RESET_BIT  = 15;
	localparam int unsigned LOOP_BIT   = 14;
	localparam int unsigned SPEED_BIT  = 13;
	localparam int unsigned AN_EN_BIT  = 12;
	localparam int unsigned DUPLEX_BIT = 8;

	// Status field positions
	localparam int unsigned ST_LINK_BIT = 0;
	localparam int unsigned ST_JAB_BIT  = 1;
	localparam int unsigned ST_FCS_BIT  = 2;
	localparam int unsigned ST_DEAD_BIT = 3;
	localparam int unsigned ST_CAP_LSB  = 12;
	localparam logic [3:0]  PERM_CAP    = 4'h6;

	localparam logic LOOP_RST = 1'b0;

	// Timing
	localparam int unsigned CLK_FREQ_MHZ     = 125;
	localparam int unsigned SW_RESET_TIME_NS = 2000;
	localparam int unsigned SW_RESET_CYCLES  = (SW_RESET_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int unsigned DEAD_TIME_US     = 500;
	localparam int unsigned DEAD_CYCLES      = DEAD_TIME_US * CLK_FREQ_MHZ;

	typedef enum logic [1:0] {RS_IDLE, RS_RUN, RS_RELOAD} rst_state_t;
endpackage : phy_bmc_pkg
`default_nettype wire

// ### testbench/mgmt_master.sv
// Management entity model: APB master driving the register port
`default_nettype none
module mgmt_master (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
	end

	// One whole word per access, held until pready is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output bit to);
		to = 1'b1;
		r = 32'h0000_0000;
		e = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				r = prdata;
				e = pslverr;
				to = 1'b0;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines never keep the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : mgmt_master
`default_nettype wire

// ### testbench/phy_basic_mode_control_tb.sv
// Self-checking bench for the basic mode control register bank
`default_nettype none
module phy_basic_mode_control_tb;
	import phy_bmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [15:0] wr;
		logic [15:0] rd;
		logic        spd;
		logic        dup;
	} row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        st_an, st_spd, st_fd, an_spd, an_fd, link_src, jab_src, fc_evt;
	logic [3:0]  txd, lrxd, rxd;
	logic        tx_en, lrx_dv, rx_dv, spd, dup, an_en, sra;
	bit          to;
	int          failures, checks, i;
	row_t        rows [7];

	phy_basic_mode_control #(.RESET_CYCLES(4), .DEAD_CYCLES(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strap_an_enable(st_an),
		.strap_speed_100(st_spd), .strap_full_duplex(st_fd), .an_speed_100(an_spd),
		.an_full_duplex(an_fd), .link_up_src(link_src), .jabber_src(jab_src),
		.false_carrier_evt(fc_evt), .mii_txd(txd), .mii_tx_en(tx_en),
		.line_rxd(lrxd), .line_rx_dv(lrx_dv), .mii_rxd(rxd), .mii_rx_dv(rx_dv),
		.link_speed_100(spd), .link_full_duplex(dup), .an_enable(an_en),
		.soft_reset_active(sra));

	mgmt_master mst_u (
		.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask : cmp_bit

	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		mst_u.xfer(w, a, d, rd, err, to);
		if (to) begin
			failures++;
			$display("unexpected at %0t: access never answered", $time);
			conclude();
		end
	endtask : acc

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		acc(1'b0, a, 32'h0000_0000);
		cmp(rd, {16'h0000, exp}, what);
		cmp_bit(err, 1'b0, "read error");
	endtask : chk_rd

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	initial begin
		presetn = 1'b0;
		st_an = 1'b0;
		st_spd = 1'b1;
		st_fd = 1'b1;
		an_spd = 1'b1;
		an_fd = 1'b0;
		link_src = 1'b1;
		jab_src = 1'b0;
		fc_evt = 1'b0;
		txd = 4'hA;
		tx_en = 1'b1;
		lrxd = 4'h5;
		lrx_dv = 1'b1;
		// Negotiated result is 100 Mb/s half duplex, so with bit 12 set the negotiated values show through
		rows = '{'{16'h0000, 16'h0000, 1'b0, 1'b0}, '{16'h2000, 16'h2000, 1'b1, 1'b0},
			'{16'h0100, 16'h0100, 1'b0, 1'b1}, '{16'h2100, 16'h2100, 1'b1, 1'b1},
			'{16'h1000, 16'h1000, 1'b1, 1'b0}, '{16'h1100, 16'h1100, 1'b1, 1'b0},
			'{16'h0EFF, 16'h0000, 1'b0, 1'b0}};
		tick(10);
		presetn <= 1'b1;
		tick(2);
		chk_rd(BMC_OFFSET, 16'h2100, "strap load");
		cmp_bit(an_en, 1'b0, "strap an");
		$display("test strap load done");

		foreach (rows[k]) begin
			acc(1'b1, BMC_OFFSET, {16'h0000, rows[k].wr});
			tick(2);
			chk_rd(BMC_OFFSET, rows[k].rd, "control readback");
			cmp_bit(spd, rows[k].spd, "speed");
			cmp_bit(dup, rows[k].dup, "duplex");
			cmp_bit(an_en, rows[k].wr[12], "an enable");
		end
		$display("test mode table done");

		// New straps must appear only through the software reset
		st_an <= 1'b1;
		st_spd <= 1'b0;
		st_fd <= 1'b0;
		// Speed and duplex set here so the reload has to clear them
		acc(1'b1, BMC_OFFSET, 32'h0000_A100);
		acc(1'b0, BMC_OFFSET, 32'h0000_0000);
		cmp_bit(rd[15], 1'b1, "reset reads one");
		cmp_bit(sra, 1'b1, "reset busy");
		for (i = 0; i < 10; i++) begin
			acc(1'b0, BMC_OFFSET, 32'h0000_0000);
			if (rd[15] === 1'b0) break;
		end
		cmp(rd, 32'h0000_1000, "restrap");
		tick(2);
		cmp_bit(sra, 1'b0, "reset over");
		cmp_bit(spd, 1'b1, "an speed");
		cmp_bit(dup, 1'b0, "an duplex");
		$display("test software reset done");

		acc(1'b1, BMC_OFFSET, 32'h0000_4000);
		tick(2);
		cmp_bit(rx_dv, 1'b0, "enable edge dv");
		tick(1);
		cmp_bit(rx_dv, 1'b0, "dead time dv");
		acc(1'b0, STAT_OFFSET, 32'h0000_0000);
		cmp_bit(rd[3], 1'b1, "dead flag set");
		tick(12);
		cmp(rxd, 32'hA, "loop data");
		cmp_bit(rx_dv, 1'b1, "loop valid");
		acc(1'b0, STAT_OFFSET, 32'h0000_0000);
		cmp_bit(rd[3], 1'b0, "dead flag clear");
		acc(1'b1, BMC_OFFSET, 32'h0000_0000);
		tick(3);
		cmp(rxd, 32'h5, "line data");
		$display("test loopback done");

		chk_rd(STAT_OFFSET, 16'h6001, "status idle");
		@(posedge pclk);
		link_src <= 1'b0;
		jab_src <= 1'b1;
		fc_evt <= 1'b1;
		@(posedge pclk);
		link_src <= 1'b1;
		jab_src <= 1'b0;
		fc_evt <= 1'b0;
		tick(2);
		chk_rd(STAT_OFFSET, 16'h6006, "latched");
		chk_rd(STAT_OFFSET, 16'h6001, "after read");
		acc(1'b1, STAT_OFFSET, 32'h0000_0FFF);
		chk_rd(STAT_OFFSET, 16'h6001, "fixed bits");
		acc(1'b1, 8'h08, 32'h0000_0000);
		cmp_bit(err, 1'b1, "unmapped");
		$display("test status bits done");

		// Hardware reset in mid-run must bring back the strap state
		presetn <= 1'b0;
		tick(2);
		cmp_bit(spd, 1'b0, "speed in reset");
		cmp_bit(an_en, 1'b0, "an in reset");
		cmp_bit(rx_dv, 1'b0, "dv in reset");
		presetn <= 1'b1;
		tick(2);
		chk_rd(BMC_OFFSET, 16'h1000, "hardware restrap");
		cmp_bit(an_en, 1'b1, "an restrapped");
		cmp_bit(spd, 1'b1, "an speed again");
		$display("test hardware reset done");
		conclude();
	end
endmodule : phy_basic_mode_control_tb
`default_nettype wire
